// ===== srs_defines.svh
// timing counts and configuration encodings for the release sequencer
`ifndef SRS_DEFINES_SVH
`define SRS_DEFINES_SVH
`define SRS_CLK_HZ        32'd200_000_000
`define SRS_TICK_CYCLES   (`SRS_CLK_HZ)
`define SRS_MIN_SECONDS   32'd60
`define SRS_PREDIS_DEF    8'h1E
`define SRS_SOL_MIN_DEF   8'h0A
`define SRS_CHIRP_CYCLES  32'd50_000_000
`define SRS_WARBLE_CYCLES 32'd25_000_000
`define SRS_PULSE_CYCLES  32'd100_000_000
`define SRS_ADDR_CTRL     12'h000
`define SRS_ADDR_PREDIS   12'h004
`define SRS_ADDR_SOL      12'h008
`define SRS_ADDR_STATUS   12'h00C
`define SRS_ADDR_FAULT    12'h010
`define SRS_CTRL_RESET    32'h0000_0000
`define SRS_CTRL_MODE_LSB 0
`define SRS_CTRL_ABT_LSB  2
`define SRS_CTRL_RST_BIT  4
`define SRS_CTRL_REL_LSB  8
`define SRS_CTRL_ALM_LSB  12
`endif

// ===== srs_pkg.sv
// types for the release sequencer
package srs_pkg;
	typedef enum logic [1:0] {
		SRS_DET_CROSS = 2'h0,
		SRS_DET_SEQ   = 2'h1,
		SRS_DET_SINGLE_ONLY = 2'h2,
		SRS_DET_OFF   = 2'h3
	} srs_det_e;
	typedef enum logic [1:0] {
		SRS_ABT_HOLD    = 2'h0,
		SRS_ABT_RESTART = 2'h1,
		SRS_ABT_NONE    = 2'h2,
		SRS_ABT_PAUSE   = 2'h3
	} srs_abt_e;
	typedef enum logic [3:0] {
		SRS_ST_IDLE    = 4'b0001,
		SRS_ST_PREDIS  = 4'b0010,
		SRS_ST_RELEASE = 4'b0100,
		SRS_ST_HOLD    = 4'b1000
	} srs_state_e;
	typedef enum logic [1:0] {
		SRS_PZ_OFF  = 2'h0,
		SRS_PZ_ON   = 2'h1,
		SRS_PZ_TONE = 2'h2
	} srs_pz_e;
	typedef struct packed {
		logic [1:0] det_cnt_a;
		logic [1:0] det_cnt_b;
		logic [1:0] single_trip;
		logic       manual_rel;
		logic       abort;
		logic       superv;
		logic [2:0] alarm_in;
	} srs_in_s;
	typedef struct packed {
		logic led_alarm;
		logic led_superv;
		logic led_trouble;
		logic normal;
		logic piezo;
	} srs_ind_s;
	typedef logic [3:0] srs_rel_t;
endpackage : srs_pkg

// ===== srs_sequencer.sv
// release sequencer: detection, delay, release, solenoid and indicators
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "srs_defines.svh"
module srs_sequencer (
	// apb
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [11:0]   paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	// field inputs, asynchronous
	input  wire srs_pkg::srs_in_s field_in,
	input  wire logic [7:0]    fault_latch_in,
	input  wire logic [7:0]    fault_clear_in,
	// outputs
	output srs_pkg::srs_rel_t  rel_out,
	output logic               solenoid,
	output srs_pkg::srs_ind_s  ind
);
	import srs_pkg::*;

	localparam int W = $bits(srs_in_s) + 16;

	// overview of the data path:
	// field contacts -> three-stage filter -> detection decode
	// detection decode -> sequencer states -> release and solenoid
	// fault lines and abort -> trouble tracking
	// states and conditions -> indicator and piezo outputs
	// every output below is registered so pins never glitch
	// the filter costs about four cycles, negligible at field speeds,
	// and keeps metastability away from the state machine
	// W covers the struct plus both eight-bit fault buses

	// a bit only moves when stages two and three agree, so a single
	// sampled glitch on a contact never reaches the decode logic
	// limitation: a contact must hold for at least two cycles
	// reset clears every stage, so all contacts read as inactive
	// until the filter has filled after reset is released
	// three-stage input sync, change accepted when stages 2 and 3 agree
	logic [W-1:0] s1_reg, s2_reg, s3_reg, in_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			in_reg <= '0;
		end else begin
			s1_reg <= {field_in, fault_latch_in, fault_clear_in};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < W; i++) begin
				if (s2_reg[i] == s3_reg[i])
					in_reg[i] <= s3_reg[i];
			end
		end
	end

	// filtered views of the inputs
	// upper bits carry the field struct, lower the two fault buses
	// only these filtered values are used past this point
	srs_in_s    fin;
	wire [7:0]  flt_latch = in_reg[15:8];
	wire [7:0]  flt_clear = in_reg[7:0];
	assign fin = in_reg[W-1:16];


	// register file notes:
	// access edge is psel and penable together, no wait states
	// pready is one pulse, raised in the first access cycle
	// the system reset bit is a strobe and never reads back set
	// unmapped offsets answer with pslverr and read as zero
	// writes to unmapped offsets are dropped without side effects
	// control fields: mode, abort type, reset strobe, masks
	// registers
	logic [31:0] ctrl_reg, ctrl_next;
	logic [7:0]  predis_reg, sol_reg;
	logic        acc;
	assign acc = psel & penable;
	wire wr = acc & pwrite;
	wire hit_ctrl   = paddr == `SRS_ADDR_CTRL;
	wire hit_predis = paddr == `SRS_ADDR_PREDIS;
	wire hit_sol    = paddr == `SRS_ADDR_SOL;
	wire hit_stat   = paddr == `SRS_ADDR_STATUS;
	wire hit_flt    = paddr == `SRS_ADDR_FAULT;
	wire hit_any = hit_ctrl | hit_predis | hit_sol | hit_stat | hit_flt;
	wire sys_reset = wr & hit_ctrl & pwdata[`SRS_CTRL_RST_BIT];
	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr && hit_ctrl)
			ctrl_next = pwdata & ~(32'h0000_0001 << `SRS_CTRL_RST_BIT);
	end

	// control field views
	// mode and abort type use the package encodings
	// release and alarm masks select which circuits take part
	// bits outside the fields read back as written
	wire [1:0] mode_a = ctrl_reg[`SRS_CTRL_MODE_LSB +: 2];
	wire [1:0] abt_ty = ctrl_reg[`SRS_CTRL_ABT_LSB +: 2];
	wire [3:0] rel_cfg = ctrl_reg[`SRS_CTRL_REL_LSB +: 4];
	wire [2:0] alm_cfg = ctrl_reg[`SRS_CTRL_ALM_LSB +: 3];


	// detection notes:
	// cross-zone wants both circuits, sequential wants a total of two
	// single-trip detectors only count when the circuits are sequential
	// modes two and three never start a countdown on their own
	// any_det feeds the premature abort check below
	// detection
	wire a_on = fin.det_cnt_a != 2'h0;
	wire b_on = fin.det_cnt_b != 2'h0;
	wire [2:0] det_sum = {1'b0, fin.det_cnt_a} + {1'b0, fin.det_cnt_b};
	wire cross_ok = (mode_a == SRS_DET_CROSS) & a_on & b_on;
	wire seq_ok = (mode_a == SRS_DET_SEQ) & (det_sum >= 3'h2);
	wire single_ok = (mode_a == SRS_DET_SEQ) & (|fin.single_trip);
	wire det_ok = cross_ok | seq_ok | single_ok;
	wire any_det = a_on | b_on | (|fin.single_trip);


	// sequencer notes:
	// idle waits for detection or manual release
	// predis counts down seconds, abort type shapes the count
	// hold is the abort-hold state: count ran out while abort held
	// release is sticky; only the reset strobe leaves it
	// manual release wins over everything except the reset strobe
	// the reset strobe wins over every transition in the same cycle
	// tick is one second of pclk, counted only outside idle
	// the second counter reloads from the delay register while idle
	// state machine
	srs_state_e st_reg, st_next;
	logic [31:0] tick_reg;
	logic [7:0]  sec_reg;
	logic [7:0]  min_reg;
	logic [5:0]  minsec_reg;
	logic        sol_reg_on;
	logic        det_seen_reg;
	wire tick = tick_reg == `SRS_TICK_CYCLES - 32'd1;
	wire abt_act = fin.abort & (abt_ty != SRS_ABT_NONE);
	wire cnt_done = sec_reg == 8'h00;

	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			SRS_ST_IDLE: begin
				if (fin.manual_rel)
					st_next = SRS_ST_RELEASE;
				else if (det_ok)
					st_next = SRS_ST_PREDIS;
			end
			SRS_ST_PREDIS: begin
				if (fin.manual_rel)
					st_next = SRS_ST_RELEASE;
				else if (cnt_done && !abt_act)
					st_next = SRS_ST_RELEASE;
				else if (cnt_done && abt_act)
					st_next = SRS_ST_HOLD;
			end
			SRS_ST_HOLD: begin
				if (fin.manual_rel || !fin.abort)
					st_next = SRS_ST_RELEASE;
			end
			SRS_ST_RELEASE: st_next = SRS_ST_RELEASE;
		endcase
		if (sys_reset)
			st_next = SRS_ST_IDLE;
	end


	// solenoid timing:
	// entering release loads the minute count and clears the seconds
	// a zero minute setting still gives one full minute on
	// the reset strobe drops the solenoid in the same cycle
	// det_seen remembers any detection since the last reset strobe
	wire entering_rel = (st_next == SRS_ST_RELEASE) &&
		(st_reg != SRS_ST_RELEASE);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg       <= SRS_ST_IDLE;
			tick_reg     <= 32'h0000_0000;
			sec_reg      <= 8'h00;
			min_reg      <= 8'h00;
			minsec_reg   <= 6'h00;
			sol_reg_on   <= 1'b0;
			det_seen_reg <= 1'b0;
		end else begin
			st_reg   <= st_next;
			tick_reg <= (tick || st_next == SRS_ST_IDLE && st_reg ==
				SRS_ST_IDLE) ? 32'h0000_0000 : tick_reg + 32'd1;
			if (any_det)
				det_seen_reg <= 1'b1;
			if (st_reg == SRS_ST_IDLE)
				sec_reg <= predis_reg;
			else if (st_reg == SRS_ST_PREDIS && abt_act &&
				abt_ty == SRS_ABT_RESTART)
				sec_reg <= predis_reg;
			else if (st_reg == SRS_ST_PREDIS && tick && !cnt_done &&
				!(abt_act && abt_ty == SRS_ABT_PAUSE))
				sec_reg <= sec_reg - 8'h01;
			if (entering_rel) begin
				sol_reg_on <= 1'b1;
				min_reg    <= sol_reg;
				minsec_reg <= 6'h00;
			end else if (sol_reg_on && tick) begin
				if (minsec_reg == 6'(`SRS_MIN_SECONDS - 32'd1)) begin
					minsec_reg <= 6'h00;
					if (min_reg <= 8'h01)
						sol_reg_on <= 1'b0;
					min_reg <= min_reg - 8'h01;
				end else
					minsec_reg <= minsec_reg + 6'h01;
			end
			if (sys_reset) begin
				sol_reg_on   <= 1'b0;
				// a detection in the strobe cycle still counts
				det_seen_reg <= any_det;
			end
		end
	end


	// trouble notes:
	// latching faults stay until the reset strobe after they clear
	// self-clearing faults follow their input through the filter
	// an abort seen before any detection latches as trouble
	// normal is simply the inverse of trouble, so they never overlap
	// trouble tracking
	logic [7:0] latched_reg;
	logic       pre_abort_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latched_reg   <= 8'h00;
			pre_abort_reg <= 1'b0;
		end else begin
			// set wins over the reset clear
			latched_reg <= (sys_reset ? 8'h00 : latched_reg) |
				flt_latch;
			pre_abort_reg <= (sys_reset ? 1'b0 : pre_abort_reg) |
				(fin.abort & ~det_seen_reg & ~any_det);
		end
	end
	// a fault line that pulses for only one sampled cycle is missed
	// clearing faults follow the condition and drop once it is gone
	wire trouble = (|latched_reg) | (|flt_clear) | pre_abort_reg;
	wire superv = fin.superv;
	wire pre_or_rel = st_reg != SRS_ST_IDLE;
	wire alarm = (|(fin.alarm_in & alm_cfg)) & ~pre_or_rel;


	// piezo notes:
	// one free-running counter feeds all three patterns
	// chirp is a short burst each period, warble a square wave,
	// pulse a half-duty tone; trouble is a steady tone
	// patterns are registered so the piezo output never glitches
	// priority: predis or release, alarm, supervisory, trouble
	// trade-off: patterns are not phase aligned to state entry,
	// so the first period after a state change may be short
	// piezo pattern generators
	logic [31:0] pz_cnt_reg;
	logic        chirp_reg, warble_reg, pulse_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pz_cnt_reg <= 32'h0000_0000;
			chirp_reg  <= 1'b0;
			warble_reg <= 1'b0;
			pulse_reg  <= 1'b0;
		end else begin
			pz_cnt_reg <= (pz_cnt_reg == `SRS_PULSE_CYCLES - 32'd1) ?
				32'h0000_0000 : pz_cnt_reg + 32'd1;
			chirp_reg  <= pz_cnt_reg < `SRS_CHIRP_CYCLES / 32'd10;
			warble_reg <= (pz_cnt_reg % `SRS_WARBLE_CYCLES) <
				`SRS_WARBLE_CYCLES / 32'd2;
			pulse_reg  <= pz_cnt_reg < `SRS_PULSE_CYCLES / 32'd2;
		end
	end

	// pattern select:
	// states first, then alarm, then supervisory, then trouble
	// silent only when nothing is active
	// combinational mux, registered at the output stage
	logic pz_val;
	always_comb begin
		if (pre_or_rel)
			pz_val = chirp_reg;
		else if (alarm)
			pz_val = pulse_reg;
		else if (superv)
			pz_val = warble_reg;
		else if (trouble)
			pz_val = 1'b1;
		else
			pz_val = 1'b0;
	end


	// output notes:
	// prdata is loaded in the setup cycle and held until the next read
	// rel_out and the red led look at the next state so they rise
	// together with the state change into release
	// ind.normal goes high at the first edge after reset if no trouble
	// the solenoid output is masked by the reset strobe directly
	// outputs and register file

	// status word:
	// [3:0] one-hot state, [4] alarm, [5] supervisory,
	// [6] trouble, upper bits read as zero
	// fault word: [15:8] latched faults, [7:0] live clearing faults
	// values are sampled at setup, so a read shows one instant
	wire [31:0] status_w = {24'h00_0000, 1'b0, trouble, superv, alarm,
		st_reg};
	logic [31:0] rd_w;
	assign rd_w = hit_ctrl ? ctrl_reg :
		hit_predis ? {24'h00_0000, predis_reg} :
		hit_sol ? {24'h00_0000, sol_reg} :
		hit_stat ? status_w :
		hit_flt ? {16'h0000, latched_reg, flt_clear} : 32'h0000_0000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg   <= `SRS_CTRL_RESET;
			predis_reg <= `SRS_PREDIS_DEF;
			sol_reg    <= `SRS_SOL_MIN_DEF;
			prdata     <= 32'h0000_0000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			rel_out    <= '0;
			solenoid   <= 1'b0;
			ind        <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
			if (wr && hit_predis)
				predis_reg <= pwdata[7:0];
			if (wr && hit_sol)
				sol_reg <= pwdata[7:0];
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit_any;
			prdata  <= (psel && !penable && !pwrite) ? rd_w : prdata;
			rel_out <= (st_next == SRS_ST_RELEASE) ? rel_cfg : 4'h0;
			solenoid <= sol_reg_on & ~sys_reset;
			ind.led_alarm   <= (st_next != SRS_ST_IDLE) | alarm;
			ind.led_superv  <= superv;
			ind.led_trouble <= trouble;
			ind.normal      <= ~trouble;
			ind.piezo       <= pz_val;
		end
	end
endmodule : srs_sequencer

// ===== srs_seq_asserts.sv
// concurrent checks on the release sequencer ports
`timescale 1ns/1ps
module srs_seq_asserts (
	// apb
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pslverr,
	// field side and outputs
	input wire srs_pkg::srs_in_s  field_in,
	input wire logic [7:0]        fault_clear_in,
	input wire srs_pkg::srs_rel_t rel_out,
	input wire logic              solenoid,
	input wire srs_pkg::srs_ind_s ind
);
	import srs_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence sys_reset_s;
		psel && penable && pwrite && paddr == 12'h000 && pwdata[4];
	endsequence
	// eight stable cycles cover the input synchroniser
	sequence superv_on_s;
		field_in.superv [*8];
	endsequence
	unmapped_read_a: assert property (psel && !penable && !pwrite
		&& paddr > 12'h010 |=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	normal_excl_a: assert property (!(ind.normal && ind.led_trouble))
		else $error("normal with trouble");
	release_red_a: assert property (rel_out != 4'h0 |-> ind.led_alarm)
		else $error("release without red led");
	superv_on_a: assert property (superv_on_s |=> ind.led_superv)
		else $error("supervisory led missing");
	superv_off_a: assert property (!field_in.superv [*8] |=> !ind.led_superv)
		else $error("supervisory led latched");
	fault_trouble_a: assert property ((fault_clear_in != 8'h00) [*8] |=> ind.led_trouble)
		else $error("fault without trouble led");
	manual_rel_a: assert property (field_in.manual_rel [*8] |=> solenoid)
		else $error("manual release ignored");
	reset_sol_a: assert property (sys_reset_s ##0 !field_in.manual_rel |-> ##[1:3] !solenoid)
		else $error("solenoid survives reset");
endmodule : srs_seq_asserts
bind srs_sequencer srs_seq_asserts srs_seq_asserts_inst (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .field_in,
	.fault_clear_in, .rel_out, .solenoid, .ind);

// ===== srs_field_model.sv
// field side: detectors, abort, manual release and supervisory contacts
`timescale 1ns/1ps
module srs_field_model (
	// clock
	input  wire logic             pclk,
	// contact levels asked for, and as seen by the sequencer
	input  wire srs_pkg::srs_in_s cmd,
	output srs_pkg::srs_in_s      field_in
);
	import srs_pkg::*;
	srs_in_s held_reg = '0;
	// contacts move only after a clock edge
	always @(posedge pclk)
		held_reg <= cmd;
	assign field_in = held_reg;
endmodule : srs_field_model

// ===== srs_sequencer_tb.sv
// self-checking bench for the release sequencer
`timescale 1ns/1ps
module srs_sequencer_tb;
	import srs_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        solenoid;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0]  fault_latch_in, fault_clear_in;
	logic [15:0] lfsr_reg;
	logic [11:0] tab [6];
	srs_in_s     field_cmd, field_in;
	srs_rel_t    rel_out;
	srs_ind_s    ind;
	logic [31:0] exp_q [$];
	int          n_errors, n_compared;
	srs_sequencer srs_sequencer_inst (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .field_in,
		.fault_latch_in, .fault_clear_in, .rel_out, .solenoid, .ind);
	srs_field_model srs_field_model_inst (.pclk, .cmd(field_cmd), .field_in);
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	function automatic logic [15:0] lfsr_step(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_step
	task automatic check(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic bit_is(input string nm, input logic seen, exp);
		check(nm, {31'h0, seen}, {31'h0, exp});
	endtask : bit_is
	task automatic stop_test;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	// d is write data, or the read data expected
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic err);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			exp_q.push_back(d);
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			n_errors++;
			stop_test();
		end
		bit_is("pslverr", pslverr, err);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// field inputs need about four cycles through the filter
	task automatic settle;
		repeat (10) @(posedge pclk);
	endtask : settle
	task automatic sys_reset(input logic [31:0] c);
		apb(1'b1, 12'h000, c | 32'h0000_0010, 1'b0);
		settle();
	endtask : sys_reset
	always @(posedge pclk)
		if (psel && penable && pready && !pwrite)
			check("prdata", prdata, exp_q.pop_front());
	initial begin
		{psel, penable, pwrite, paddr, pwdata, field_cmd} = '0;
		{fault_latch_in, fault_clear_in} = '0;
		presetn = 1'b0;
		lfsr_reg = 16'hA900;
		// mode, count a, count b, single trip, state expected
		tab = '{12'h041, 12'h051, 12'h441, 12'h452, 12'h412, 12'h011};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0000_0000, 1'b0);
		apb(1'b0, 12'h004, 32'h0000_001E, 1'b0);
		apb(1'b0, 12'h008, 32'h0000_000A, 1'b0);
		apb(1'b0, 12'h00C, 32'h0000_0001, 1'b0);
		apb(1'b0, 12'h020, 32'h0000_0000, 1'b1);
		apb(1'b1, 12'h040, 32'hFFFF_FFFF, 1'b1);
		// a zero delay would release at once, so bit 0 is kept set
		for (int k = 1; k < 3; k++) begin
			lfsr_reg = lfsr_step(lfsr_reg);
			apb(1'b1, 12'(4 * k), {16'h0000, lfsr_reg | 16'h0001}, 1'b0);
			apb(1'b0, 12'(4 * k), {24'h00_0000, lfsr_reg[7:0] | 8'h01}, 1'b0);
		end
		foreach (tab[k]) begin
			field_cmd <= '0;
			settle();
			sys_reset({30'h0, tab[k][11:10]} | 32'h0000_0008);
			field_cmd.det_cnt_a <= tab[k][9:8];
			field_cmd.det_cnt_b <= tab[k][7:6];
			field_cmd.single_trip <= tab[k][5:4];
			settle();
			apb(1'b0, 12'h00C, {28'h000_0000, tab[k][3:0]}, 1'b0);
			bit_is("alarm led", ind.led_alarm, tab[k][1]);
		end
		field_cmd <= '0;
		settle();
		sys_reset(32'h0000_0000);
		field_cmd.abort <= 1'b1;
		settle();
		bit_is("trouble led", ind.led_trouble, 1'b1);
		bit_is("normal", ind.normal, 1'b0);
		bit_is("piezo", ind.piezo, 1'b1);
		field_cmd.abort <= 1'b0;
		settle();
		bit_is("trouble led", ind.led_trouble, 1'b1);
		sys_reset(32'h0000_0000);
		bit_is("normal", ind.normal, 1'b1);
		fault_clear_in <= 8'h01;
		settle();
		bit_is("trouble led", ind.led_trouble, 1'b1);
		fault_clear_in <= 8'h00;
		fault_latch_in <= 8'h80;
		settle();
		fault_latch_in <= 8'h00;
		settle();
		bit_is("trouble led", ind.led_trouble, 1'b1);
		sys_reset(32'h0000_0000);
		bit_is("trouble led", ind.led_trouble, 1'b0);
		field_cmd.superv <= 1'b1;
		settle();
		bit_is("superv led", ind.led_superv, 1'b1);
		field_cmd.superv <= 1'b0;
		settle();
		bit_is("superv led", ind.led_superv, 1'b0);
		sys_reset(32'h0000_0A08);
		field_cmd.manual_rel <= 1'b1;
		settle();
		check("rel_out", {28'h000_0000, rel_out}, 32'h0000_000A);
		bit_is("solenoid", solenoid, 1'b1);
		apb(1'b0, 12'h00C, 32'h0000_0004, 1'b0);
		field_cmd.manual_rel <= 1'b0;
		settle();
		bit_is("solenoid", solenoid, 1'b1);
		bit_is("alarm led", ind.led_alarm, 1'b1);
		apb(1'b1, 12'h000, 32'h0000_0A18, 1'b0);
		repeat (3) @(posedge pclk);
		bit_is("solenoid", solenoid, 1'b0);
		stop_test();
	end
endmodule : srs_sequencer_tb
